//--- alae_pkg.sv
// Constants, opcodes, register map and carrier types for the add/logic/atomic/branch executor.
// Assumes a single core clock domain and 32-bit Wishbone register and memory buses.
//
// Functional notes
// - Add-with-carry sums both sources plus cc bit 1, keeps low 32 bits.
// - Add-with-carry puts the carry out of bit 31 into cc bit 1.
// - Add-with-carry sets cc bit 0 on signed overflow, else clears it.
// - Add-with-carry always clears cc bit 2.
// - Add-with-carry never raises the overflow fault.
// - Ordinal and integer add share the result; integer overflow sets flag or faults per mask.
// - Conditional add runs when cc AND mask nonzero, or cc zero for zero mask.
// - Conditional add mask comes from opcode bits 4 to 6.
// - Bit-alter copies source, bit pos mod 32 set when cc bit 1 else cleared.
// - And writes the bitwise AND of both sources.
// - And-not writes second source AND inverse of first source.
// - Atomic add reads memory, writes word plus source, returns old word.
// - Bus is locked from atomic read until its write completes; others honour it.
// - Atomic addresses have their two low bits forced to zero.
// - Short branch uses signed 24-bit displacement; extended loads full address; low IP bits zero.
package alae_pkg;

    // ****************************************
    // Opcodes (branch opcodes are the 8-bit major opcode shifted up by four)
    // ****************************************
    localparam logic [11:0] OP_ADDC = 12'h5B0;
    localparam logic [11:0] OP_ADDO = 12'h590;
    localparam logic [11:0] OP_ADDI = 12'h591;
    localparam logic [11:0] OP_ALTERBIT = 12'h58F;
    localparam logic [11:0] OP_AND = 12'h581;
    localparam logic [11:0] OP_ANDNOT = 12'h582;
    localparam logic [11:0] OP_ATADD = 12'h612;
    localparam logic [11:0] OP_ATMOD = 12'h610;
    localparam logic [11:0] OP_BR = 12'h080;
    localparam logic [11:0] OP_BRX = 12'h840;
    localparam logic [3:0] OP_CADD_HI = 4'h7;
    localparam int CADD_MASK_LSB = 4;

    // ****************************************
    // Register map (byte addresses) and fields
    // ****************************************
    localparam logic [7:0] ADDR_ARITH = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_GPR_BASE = 8'h80;
    localparam int ARITH_OF_BIT = 3;
    localparam int ARITH_OM_BIT = 4;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;
    localparam int IRQ_ATOM_BIT = 2;
    localparam logic [2:0] RST_CC = 3'h0;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam logic [31:0] WORD_ALIGN_MASK = 32'hFFFFFFFC;

    typedef enum {
        OPC_NONE, OPC_ADDC, OPC_ADDO, OPC_ADDI, OPC_CADD, OPC_ALTER,
        OPC_AND, OPC_ANDNOT, OPC_ATADD, OPC_ATMOD, OPC_BR, OPC_BRX
    } alae_op_e;

    typedef struct packed {
        logic [11:0] opcode;
        logic [4:0] src1Idx;
        logic src1Lit;
        logic [4:0] src2Idx;
        logic src2Lit;
        logic [4:0] dstIdx;
        logic [31:0] ip;
        logic [23:0] disp;
        logic [31:0] effAddr;
    } alae_req_s;

    typedef struct packed {
        logic done;
        logic fault;
        logic branch;
        logic [31:0] ipNext;
    } alae_resp_s;

endpackage

//--- alae_exec.sv
// Executor for add, conditional add, bit alter, and/and-not, atomic add/modify and branches.
// Assumes a Wishbone classic register slave, a lockable Wishbone classic memory master and
// a memQuiet input that is high once all earlier memory accesses are complete.
`timescale 1ns/1ps
module alae_exec
    import alae_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic reqValid,
    output logic reqReady,
    input wire alae_pkg::alae_req_s req,
    output alae_pkg::alae_resp_s resp,
    // Register slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    output logic irq,
    // Memory master
    input wire logic memQuiet,
    output logic mCyc,
    output logic mStb,
    output logic mWe,
    output logic mLock,
    output logic [31:0] mAdr,
    output logic [31:0] mDatW,
    input wire logic [31:0] mDatR,
    input wire logic mAck
);

    // ****************************************
    // Types, functions and state
    // ****************************************
    typedef enum {ST_IDLE, ST_SYNC, ST_READ, ST_WRITE} alae_state_e;

    function automatic alae_op_e decodeOp(input logic [11:0] opc);
        alae_op_e o;
        o = OPC_NONE;
        if (opc == OP_ADDC) o = OPC_ADDC;
        else if (opc == OP_ADDO) o = OPC_ADDO;
        else if (opc == OP_ADDI) o = OPC_ADDI;
        else if (opc == OP_ALTERBIT) o = OPC_ALTER;
        else if (opc == OP_AND) o = OPC_AND;
        else if (opc == OP_ANDNOT) o = OPC_ANDNOT;
        else if (opc == OP_ATADD) o = OPC_ATADD;
        else if (opc == OP_ATMOD) o = OPC_ATMOD;
        else if (opc == OP_BR) o = OPC_BR;
        else if (opc == OP_BRX) o = OPC_BRX;
        else if (opc[11:8] == OP_CADD_HI && opc[7] && opc[3:1] == 3'h0) o = OPC_CADD;
        return o;
    endfunction

    // 33-bit sum so the carry out of bit 31 is kept
    function automatic logic [32:0] add33(input logic [31:0] a, input logic [31:0] b, input logic cin);
        return {1'b0, a} + {1'b0, b} + {32'h0, cin};
    endfunction

    function automatic logic sgnOvf(input logic [31:0] a, input logic [31:0] b, input logic [31:0] r);
        return (a[31] == b[31]) && (a[31] != r[31]);
    endfunction

    alae_state_e stateReg;
    logic [31:0] gpr [32];
    logic [2:0] ccReg;
    logic ofReg;
    logic omReg;
    logic [2:0] irqStatReg;
    logic [2:0] irqMaskReg;
    alae_resp_s respReg;
    logic [4:0] atDstReg;
    logic atModReg;
    logic [31:0] atOpndReg;
    logic [31:0] atMaskReg;
    logic [31:0] atOldReg;

    // ****************************************
    // Operand fetch and execution
    // ****************************************
    alae_op_e op;
    logic [31:0] s1;
    logic [31:0] s2;
    logic [32:0] sum;
    logic ovf;
    logic [2:0] cmask;
    logic condOk;
    logic [31:0] res;
    logic wrDst;
    logic ccWr;
    logic [2:0] ccNext;
    logic ofSet;
    logic fault;
    logic [31:0] bitMask;
    logic [31:0] brTarget;
    logic accept;

    assign reqReady = (stateReg == ST_IDLE);
    assign accept = reqValid && reqReady;

    always_comb
    begin
        op = decodeOp(req.opcode);
        s1 = req.src1Lit ? {27'h0, req.src1Idx} : gpr[req.src1Idx];
        s2 = req.src2Lit ? {27'h0, req.src2Idx} : gpr[req.src2Idx];
        cmask = req.opcode[CADD_MASK_LSB +: 3];
        condOk = (cmask == 3'h0) ? (ccReg == 3'h0) : ((cmask & ccReg) != 3'h0);
        sum = add33(s1, s2, (op == OPC_ADDC) ? ccReg[1] : 1'b0);
        ovf = sgnOvf(s1, s2, sum[31:0]);
        bitMask = 32'h1 << s1[4:0];
        res = sum[31:0];
        wrDst = 1'b0;
        ccWr = 1'b0;
        ccNext = ccReg;
        ofSet = 1'b0;
        fault = 1'b0;
        brTarget = 32'h0;
        case (op)
            OPC_ADDC:
            begin
                wrDst = 1'b1;
                ccWr = 1'b1;
                ccNext = {1'b0, sum[32], ovf};
            end
            OPC_ADDO: wrDst = 1'b1;
            OPC_ADDI:
            begin
                wrDst = 1'b1;
                ofSet = ovf && omReg;
                fault = ovf && !omReg;
            end
            OPC_CADD:
            begin
                wrDst = condOk;
                ofSet = condOk && req.opcode[0] && ovf && omReg;
                fault = condOk && req.opcode[0] && ovf && !omReg;
            end
            OPC_ALTER:
            begin
                wrDst = 1'b1;
                res = ccReg[1] ? (s2 | bitMask) : (s2 & ~bitMask);
            end
            OPC_AND:
            begin
                wrDst = 1'b1;
                res = s2 & s1;
            end
            OPC_ANDNOT:
            begin
                wrDst = 1'b1;
                res = s2 & ~s1;
            end
            OPC_BR: brTarget = (req.ip + {{8{req.disp[23]}}, req.disp}) & WORD_ALIGN_MASK;
            OPC_BRX: brTarget = req.effAddr & WORD_ALIGN_MASK;
            default: wrDst = 1'b0;
        endcase
    end

    // ****************************************
    // Register file
    // ****************************************
    // Only final results are written; atomics write at the end of the memory write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 32; i++)
                gpr[i] <= 32'h0;
        end
        else if (stateReg == ST_WRITE && mStb && mAck)
        begin
            gpr[atDstReg] <= atOldReg;
        end
        else if (accept && wrDst)
        begin
            gpr[req.dstIdx] <= res;
        end
    end

    // ****************************************
    // Atomic sequencer
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stateReg <= ST_IDLE;
            mCyc <= 1'b0;
            mStb <= 1'b0;
            mWe <= 1'b0;
            mLock <= 1'b0;
            mAdr <= 32'h0;
            mDatW <= 32'h0;
            atDstReg <= 5'h0;
            atModReg <= 1'b0;
            atOpndReg <= 32'h0;
            atMaskReg <= 32'h0;
            atOldReg <= 32'h0;
        end
        else
        begin
            case (stateReg)
                ST_IDLE:
                    if (accept && (op == OPC_ATADD || op == OPC_ATMOD))
                    begin
                        mAdr <= s1 & WORD_ALIGN_MASK;
                        atModReg <= (op == OPC_ATMOD);
                        atDstReg <= req.dstIdx;
                        atMaskReg <= s2;
                        // Atomic modify takes its source from the destination register
                        atOpndReg <= (op == OPC_ATMOD) ? gpr[req.dstIdx] : s2;
                        stateReg <= ST_SYNC;
                    end
                ST_SYNC:
                    if (memQuiet)
                    begin
                        mCyc <= 1'b1;
                        mStb <= 1'b1;
                        mWe <= 1'b0;
                        mLock <= 1'b1;
                        stateReg <= ST_READ;
                    end
                ST_READ:
                    if (mAck)
                    begin
                        // Strobe drops for one cycle between read and write; cycle and lock stay high
                        mStb <= 1'b0;
                        mWe <= 1'b1;
                        atOldReg <= mDatR;
                        if (atModReg)
                            mDatW <= (mDatR & ~atMaskReg) | (atOpndReg & atMaskReg);
                        else
                            mDatW <= mDatR + atOpndReg;
                        stateReg <= ST_WRITE;
                    end
                ST_WRITE:
                    if (!mStb)
                        mStb <= 1'b1;
                    else if (mAck)
                    begin
                        mCyc <= 1'b0;
                        mStb <= 1'b0;
                        mWe <= 1'b0;
                        mLock <= 1'b0;
                        stateReg <= ST_IDLE;
                    end
                default: stateReg <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Responses
    // ****************************************
    logic atDone;
    assign atDone = (stateReg == ST_WRITE) && mStb && mAck;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            respReg <= '0;
        end
        else
        begin
            respReg.done <= (accept && op != OPC_ATADD && op != OPC_ATMOD) || atDone;
            respReg.fault <= accept && fault;
            respReg.branch <= accept && (op == OPC_BR || op == OPC_BRX);
            if (accept && (op == OPC_BR || op == OPC_BRX))
                respReg.ipNext <= brTarget;
        end
    end
    assign resp = respReg;

    // ****************************************
    // Arithmetic controls
    // ****************************************
    logic swWr;
    logic swRd;
    logic [31:0] rdMux;
    assign swWr = wbCyc && wbStb && wbWe && !wbAck;
    assign swRd = wbCyc && wbStb && !wbWe && !wbAck;

    // Execution updates win over a software write in the same cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ccReg <= RST_CC;
            ofReg <= 1'b0;
            omReg <= 1'b0;
        end
        else
        begin
            if (accept && ccWr)
                ccReg <= ccNext;
            else if (swWr && wbAdr == ADDR_ARITH && wbSel[0])
                ccReg <= wbDatW[2:0];
            if (accept && ofSet)
                ofReg <= 1'b1;
            else if (swWr && wbAdr == ADDR_ARITH && wbSel[0])
                ofReg <= wbDatW[ARITH_OF_BIT];
            if (swWr && wbAdr == ADDR_ARITH && wbSel[0])
                omReg <= wbDatW[ARITH_OM_BIT];
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    logic [2:0] irqEvt;
    assign irqEvt = {atDone, accept && fault, accept && ofSet};

    // Read of the status register clears it, but a same-cycle event is kept
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqStatReg <= RST_IRQ;
            irqMaskReg <= RST_IRQ;
        end
        else
        begin
            irqStatReg <= ((swRd && wbAdr == ADDR_IRQ_STATUS) ? 3'h0 : irqStatReg) | irqEvt;
            if (swWr && wbAdr == ADDR_IRQ_MASK && wbSel[0])
                irqMaskReg <= wbDatW[2:0];
        end
    end
    assign irq = |(irqStatReg & irqMaskReg);

    // ****************************************
    // Register slave
    // ****************************************
    always_comb
    begin
        rdMux = 32'h0;
        if (wbAdr == ADDR_ARITH)
            rdMux = {27'h0, omReg, ofReg, ccReg};
        else if (wbAdr == ADDR_IRQ_STATUS)
            rdMux = {29'h0, irqStatReg};
        else if (wbAdr == ADDR_IRQ_MASK)
            rdMux = {29'h0, irqMaskReg};
        else if (wbAdr[7] && wbAdr[1:0] == 2'h0)
            rdMux = gpr[wbAdr[6:2]];
    end

    // One wait state: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wbAck <= 1'b0;
            wbDatR <= 32'h0;
        end
        else
        begin
            wbAck <= wbCyc && wbStb && !wbAck;
            if (swRd)
                wbDatR <= rdMux;
        end
    end

endmodule

//--- alae_exec_asserts.sv
// Checker for alae_exec: memory lock, word alignment, issue and response timing.
// Sees only the executor's ports; bound at the foot of this file.
`timescale 1ns/1ps
module alae_exec_asserts
    import alae_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire alae_pkg::alae_req_s req,
    input wire alae_pkg::alae_resp_s resp,
    input wire logic memQuiet,
    input wire logic mCyc,
    input wire logic mStb,
    input wire logic mWe,
    input wire logic mLock,
    input wire logic [31:0] mAdr,
    input wire logic mAck
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ****
    // Atomic memory cycle
    // ****
    sequence readStart;
        $rose(mCyc) ##0 !mWe;
    endsequence
    sequence writeAck;
        mCyc && mWe && mStb && mAck;
    endsequence
    logic taken;
    assign taken = reqValid && reqReady;

    bus_locked_a: assert property (mCyc |-> mLock) else $error("memory cycle without lock");
    word_aligned_a: assert property (mCyc |-> mAdr[1:0] == 2'h0) else $error("unaligned address");
    quiet_first_a: assert property (readStart |-> $past(memQuiet)) else $error("read before quiet");
    lock_release_a: assert property (writeAck |=> !mCyc && !mLock && resp.done && reqReady)
        else $error("atomic did not finish after write");
    issue_held_a: assert property (mCyc |-> !reqReady) else $error("issue open during atomic");
    same_word_a: assert property ($rose(mWe) |-> mCyc && $stable(mAdr)) else $error("write moved");

    // ****
    // Issue and response
    // ****
    alu_done_a: assert property (taken && req.opcode != OP_ATADD && req.opcode != OP_ATMOD |=> resp.done)
        else $error("no done after issue");
    carry_nofault_a: assert property (taken && req.opcode == OP_ADDC |=> !resp.fault)
        else $error("fault on carry add");
    far_target_a: assert property (taken && req.opcode == OP_BRX |=>
        resp.branch && resp.ipNext == ($past(req.effAddr) & WORD_ALIGN_MASK)) else $error("bad far target");
endmodule

bind alae_exec alae_exec_asserts i_chk (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .resp(resp), .memQuiet(memQuiet), .mCyc(mCyc), .mStb(mStb), .mWe(mWe), .mLock(mLock),
    .mAdr(mAdr), .mAck(mAck));

//--- alae_mem_model.sv
// Behavioural memory slave on the executor's far side.
// Assumes classic Wishbone cycles; answers after lag waiting cycles.
`timescale 1ns/1ps
module alae_mem_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] lag,
    input wire logic mCyc,
    input wire logic mStb,
    input wire logic mWe,
    input wire logic [31:0] mAdr,
    input wire logic [31:0] mDatW,
    output logic [31:0] mDatR,
    output logic mAck
);
    logic [31:0] mem [0:15];
    logic [1:0] waited;

    initial
        for (int i = 0; i < 16; i++)
            mem[i] = 32'hA5C30000 + i;

    // ****
    // Slave
    // ****
    // Sole other party; it never touches a word on its own, so a held lock is honoured
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mAck <= 1'b0;
            waited <= 2'h0;
            mDatR <= 32'h0;
        end
        else if (mCyc && mStb && !mAck && waited == lag)
        begin
            mAck <= 1'b1;
            waited <= 2'h0;
            mDatR <= mWe ? ~mDatR : mem[mAdr[5:2]];
            if (mWe)
                mem[mAdr[5:2]] <= mDatW;
        end
        else
        begin
            // Read data is stale outside the ack, so it keeps changing
            mAck <= 1'b0;
            waited <= mCyc && mStb && !mAck ? waited + 2'h1 : 2'h0;
            mDatR <= ~mDatR;
        end
    end
endmodule

//--- alae_exec_tb_top.sv
// Bench for alae_exec: random ALU traffic, branches, atomics, registers and interrupt.
// Assumes alae_pkg, alae_mem_model and the bound checker.
`timescale 1ns/1ps
module alae_exec_tb_top;
    import alae_pkg::*;
    alae_req_s req;
    alae_resp_s resp;
    logic clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, memQuiet = 1'b1;
    logic reqReady, wbAck, irq, mCyc, mStb, mWe, mLock, mAck, of = 1'b0, om = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'hF;
    logic [31:0] wbDatW = 32'h0, wbDatR, mAdr, mDatW, mDatR, lastIp = 32'h0;
    logic [31:0] gm [8];
    logic [31:0] mm [8];
    logic [2:0] cc = 3'h0, stat = 3'h0, msk = 3'h0;
    logic [1:0] lag = 2'h0;
    logic [31:0] wbQ [$];
    logic [33:0] respQ [$];
    logic [11:0] ops [6] = '{OP_ADDC, OP_ADDO, OP_ADDI, OP_ALTERBIT, OP_AND, OP_ANDNOT};
    int fail_count = 0, checks_done = 0, seed = 41;

    always #4 clk = ~clk;

    alae_exec i_dut (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady), .req(req), .resp(resp),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
        .wbAck(wbAck), .irq(irq), .memQuiet(memQuiet), .mCyc(mCyc), .mStb(mStb), .mWe(mWe), .mLock(mLock),
        .mAdr(mAdr), .mDatW(mDatW), .mDatR(mDatR), .mAck(mAck));
    alae_mem_model i_mem (.clk(clk), .rst_n(rst_n), .lag(lag), .mCyc(mCyc), .mStb(mStb), .mWe(mWe),
        .mAdr(mAdr), .mDatW(mDatW), .mDatR(mDatR), .mAck(mAck));

    // ****
    // Checking and closing
    // ****
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
        checks_done++;
        if (s !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Results are matched in order of issue, oldest note first
    always @(posedge clk)
    begin
        if (rst_n && wbAck && !wbWe)
            chk("register read", {2'b00, wbQ.pop_front()}, {2'b00, wbDatR});
        if (rst_n && resp.done)
            chk("response", respQ.pop_front(), {resp.fault, resp.branch, resp.ipNext});
    end

    // ****
    // Drivers
    // ****
    task automatic await(input logic onBus);
        for (int i = 0; i <= 200; i++)
        begin
            if (i == 200)
            begin
                fail_count++;
                conclude();
            end
            @(posedge clk);
            if (onBus ? wbAck : reqReady)
                break;
        end
    endtask

    // Leaves the request up so the next one can follow back to back
    task automatic issue(input alae_req_s r);
        req <= r;
        reqValid <= 1'b1;
        await(1'b0);
    endtask

    task automatic idle(input int n);
        reqValid <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        reqValid <= 1'b0;
        {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'b11, we, a, d};
        await(1'b1);
        {wbCyc, wbStb} <= 2'b00;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wbQ.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic setAc(input logic [4:0] v);
        {om, of, cc} = v;
        wb(1'b1, ADDR_ARITH, {27'h0, v});
    endtask

    task automatic alu(input logic [11:0] op, input logic [4:0] s1, s2, d, input logic l1, l2);
        logic [31:0] a, b, x;
        logic [32:0] s;
        logic ov, f, run;
        s1 = l1 ? s1 : s1 & 5'h7;
        s2 = l2 ? s2 : s2 & 5'h7;
        d = d & 5'h7;
        a = l1 ? {27'h0, s1} : gm[s1[2:0]];
        b = l2 ? {27'h0, s2} : gm[s2[2:0]];
        s = {1'b0, a} + {1'b0, b} + {32'h0, op == OP_ADDC && cc[1]};
        x = s[31:0];
        ov = a[31] == b[31] && x[31] != a[31];
        f = 1'b0;
        run = op[11:8] != OP_CADD_HI || (op[6:4] == 3'h0 ? cc == 3'h0 : |(op[6:4] & cc));
        case (op)
            OP_ALTERBIT: x = cc[1] ? b | (32'h1 << a[4:0]) : b & ~(32'h1 << a[4:0]);
            OP_AND: x = b & a;
            OP_ANDNOT: x = b & ~a;
            OP_ADDC: cc = {1'b0, s[32], ov};
            default: ;
        endcase
        if (run && ov && (op == OP_ADDI || (op[11:8] == OP_CADD_HI && op[0])))
        begin
            of = of | om;
            stat = stat | {1'b0, !om, om};
            f = !om;
        end
        if (run)
            gm[d[2:0]] = x;
        respQ.push_back({f, 1'b0, lastIp});
        issue(alae_req_s'{opcode: op, src1Idx: s1, src1Lit: l1, src2Idx: s2, src2Lit: l2, dstIdx: d, default: '0});
    endtask

    task automatic br(input logic [11:0] op, input logic [31:0] ip, input logic [23:0] disp, input logic [31:0] ea);
        lastIp = (op == OP_BR ? ip + {{8{disp[23]}}, disp} : ea) & WORD_ALIGN_MASK;
        respQ.push_back({2'b01, lastIp});
        issue(alae_req_s'{opcode: op, ip: ip, disp: disp, effAddr: ea, default: '0});
    endtask

    // Address goes through r7 first; quiet is withheld for two cycles
    task automatic atom(input logic [11:0] op, input logic [4:0] ad, v, d);
        logic [31:0] old;
        alu(OP_ADDO, ad, 5'h0, 5'h7, 1'b1, 1'b1);
        d = d & 5'h7;
        old = mm[ad[4:2]];
        mm[ad[4:2]] = op == OP_ATADD ? old + {27'h0, v} : (old & ~{27'h0, v}) | (gm[d] & {27'h0, v});
        gm[d] = old;
        stat[IRQ_ATOM_BIT] = 1'b1;
        lag <= 2'($random(seed));
        memQuiet <= 1'b0;
        respQ.push_back({2'b00, lastIp});
        issue(alae_req_s'{opcode: op, src1Idx: 5'h7, src2Idx: v, src2Lit: 1'b1, dstIdx: d, default: '0});
        // Taken: withdraw, or a second atomic would stand offered while refused
        reqValid <= 1'b0;
        repeat (2) @(posedge clk);
        memQuiet <= 1'b1;
    endtask

    task automatic regs;
        idle(3);
        for (int i = 0; i < 8; i++)
            rd(ADDR_GPR_BASE + 8'(4 * i), gm[i]);
        rd(ADDR_ARITH, {27'h0, om, of, cc});
    endtask

    // ****
    // Main sequence
    // ****
    initial
    begin
        req = '0;
        for (int i = 0; i < 8; i++)
        begin
            gm[i] = 32'h0;
            mm[i] = 32'hA5C30000 + i;
        end
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(1'b1, 8'h40, 32'hFFFFFFFF);
        wb(1'b1, ADDR_GPR_BASE + 8'h04, 32'h1234);
        rd(8'h40, 32'h0);
        // Lane 0 off: arithmetic controls must keep their reset value
        wbSel <= 4'hE;
        wb(1'b1, ADDR_ARITH, 32'h1F);
        wbSel <= 4'hF;
        regs();
        wb(1'b1, ADDR_IRQ_MASK, 32'h7);
        msk = 3'h7;
        setAc(5'h02);
        alu(OP_ALTERBIT, 5'h1F, 5'h0, 5'h1, 1'b1, 1'b1);
        alu(OP_ADDI, 5'h1, 5'h1, 5'h2, 1'b0, 1'b0);
        alu(OP_ADDC, 5'h1, 5'h1, 5'h3, 1'b0, 1'b0);
        idle(3);
        chk("irq", {33'h0, |(stat & msk)}, {33'h0, irq});
        rd(ADDR_IRQ_STATUS, {29'h0, stat});
        stat = 3'h0;
        setAc(5'h10);
        alu(OP_ADDI, 5'h1, 5'h1, 5'h2, 1'b0, 1'b0);
        wb(1'b1, ADDR_IRQ_MASK, 32'h0);
        msk = 3'h0;
        idle(2);
        chk("irq masked", {33'h0, |(stat & msk)}, {33'h0, irq});
        wb(1'b1, ADDR_IRQ_MASK, 32'h1);
        msk = 3'h1;
        idle(2);
        chk("irq unmasked", {33'h0, |(stat & msk)}, {33'h0, irq});
        rd(ADDR_IRQ_STATUS, {29'h0, stat});
        stat = 3'h0;
        idle(2);
        chk("irq cleared", {33'h0, irq}, 34'h0);
        regs();
        for (int i = 0; i < 64; i++)
        begin
            if (i % 4 == 0)
                setAc(5'($random(seed)));
            alu(i < 16 ? {4'h7, 1'b1, 3'(i >> 1), 3'h0, i[0]} : ops[$unsigned($random(seed)) % 6],
                5'($random(seed)), 5'($random(seed)), 5'($random(seed)), 1'($random(seed)), 1'($random(seed)));
        end
        regs();
        for (int i = 0; i < 6; i++)
            br(i[0] ? OP_BRX : OP_BR, $random(seed), 24'($random(seed)), $random(seed));
        for (int i = 0; i < 6; i++)
            atom(i[0] ? OP_ATMOD : OP_ATADD, 5'($random(seed)), 5'($random(seed)), 5'($random(seed)));
        alu(OP_AND, 5'h3, 5'h6, 5'h5, 1'b0, 1'b0);
        idle(40);
        for (int i = 0; i < 8; i++)
            chk("memory word", {2'b00, mm[i]}, {2'b00, i_mem.mem[i]});
        regs();
        rd(ADDR_IRQ_STATUS, {29'h0, stat});
        idle(4);
        chk("pending notes", 34'h0, 34'(respQ.size() + wbQ.size()));
        conclude();
    end
endmodule
